// File: common/charger_cfg_pkg.sv
package charger_cfg_pkg;

    // Register offsets as seen by the serial protocol engine.
    localparam logic [7:0] THRESH_OFS = 8'h05;
    localparam logic [7:0] TIMER_OFS = 8'h06;
    localparam logic [7:0] FUNC1_OFS = 8'h07;

    // Reset values of the three registers.
    localparam logic [7:0] THRESH_RST = 8'h6B;
    localparam logic [7:0] TIMER_RST = 8'h38;
    localparam logic [7:0] FUNC1_RST = 8'h04;

    // Field positions in the threshold register.
    localparam int RCH_DIS_BIT = 7;
    localparam int RCH_SEL_LSB = 5;
    localparam int TRK_SEL_LSB = 3;
    localparam int WEAK_SEL_LSB = 0;

    // Field positions in the timer register.
    localparam int TEND_EN_BIT = 5;
    localparam int CHG_TMR_EN_BIT = 4;
    localparam int CHG_TMR_PER_BIT = 3;
    localparam int WD_EN_BIT = 2;
    localparam int WD_PER_BIT = 1;
    localparam int WD_KICK_BIT = 0;

    // Field positions in the function register.
    localparam int DEV_DIS_BIT = 6;
    localparam int BMON_FORCE_BIT = 5;
    localparam int THR_FORCE_BIT = 4;
    localparam int REG_DIS_BIT = 3;
    localparam int EOC_EN_BIT = 2;
    localparam int CHG_EN_BIT = 0;

    // Timing, each figure in its own unit, and the derived cycle counts.
    localparam int TMR_W = 36;
    localparam logic [35:0] CLK_HZ = 36'h0_0BEB_C200;
    localparam logic [35:0] MS_PER_S = 36'h0_0000_03E8;
    localparam logic [35:0] WD_SHORT_S = 36'h0_0000_0020;
    localparam logic [35:0] WD_LONG_S = 36'h0_0000_0040;
    localparam logic [35:0] DEGLITCH_MS = 36'h0_0000_001F;
    localparam logic [35:0] WD_SHORT_CYC = WD_SHORT_S * CLK_HZ;
    localparam logic [35:0] WD_LONG_CYC = WD_LONG_S * CLK_HZ;
    localparam logic [35:0] DEGLITCH_CYC = (DEGLITCH_MS * CLK_HZ + MS_PER_S - 36'h0_0000_0001)
        / MS_PER_S;

    // One register request from the serial protocol engine.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Decoded configuration handed to the charger core.
    typedef struct packed {
        logic recharge_disable;
        logic [1:0] recharge_threshold_sel;
        logic [1:0] trickle_to_fast_threshold_sel;
        logic [2:0] weak_battery_threshold_sel;
        logic charge_complete_timer_enable;
        logic charge_safety_timer_enable;
        logic charge_timer_period_sel;
        logic watchdog_enable;
        logic watchdog_period_sel;
        logic device_disable;
        logic battery_monitor_force_on;
        logic thermistor_source_force_on;
        logic regulator_disable;
        logic end_of_charge_enable;
        logic charging_enable;
    } cfg_t;

    // Controls toward the analog section.
    typedef struct packed {
        logic battery_monitor_on;
        logic thermistor_source_on;
        logic regulator_on;
        logic iso_switch_forced_on;
        logic iso_switch_forced_off;
        logic device_shutdown;
    } analog_t;

    localparam cfg_t CFG_RST = '{
        recharge_disable: THRESH_RST[RCH_DIS_BIT],
        recharge_threshold_sel: THRESH_RST[RCH_SEL_LSB+:2],
        trickle_to_fast_threshold_sel: THRESH_RST[TRK_SEL_LSB+:2],
        weak_battery_threshold_sel: THRESH_RST[WEAK_SEL_LSB+:3],
        charge_complete_timer_enable: TIMER_RST[TEND_EN_BIT],
        charge_safety_timer_enable: TIMER_RST[CHG_TMR_EN_BIT],
        charge_timer_period_sel: TIMER_RST[CHG_TMR_PER_BIT],
        watchdog_enable: TIMER_RST[WD_EN_BIT],
        watchdog_period_sel: TIMER_RST[WD_PER_BIT],
        device_disable: FUNC1_RST[DEV_DIS_BIT],
        battery_monitor_force_on: FUNC1_RST[BMON_FORCE_BIT],
        thermistor_source_force_on: FUNC1_RST[THR_FORCE_BIT],
        regulator_disable: FUNC1_RST[REG_DIS_BIT],
        end_of_charge_enable: FUNC1_RST[EOC_EN_BIT],
        charging_enable: FUNC1_RST[CHG_EN_BIT]
    };

endpackage : charger_cfg_pkg

// File: hw/level_sync3.sv
`timescale 1ns/1ps
`default_nettype none

module level_sync3 #(
    parameter int W = 3
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] level_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_t;

    sync_state_t s_ff;
    sync_state_t nxt_s;

    // A bit changes only once the second and third stages agree, which filters one-stage glitches.
    always_comb begin
        nxt_s = s_ff;
        nxt_s.s1 = async_i;
        nxt_s.s2 = s_ff.s1;
        nxt_s.s3 = s_ff.s2;
        nxt_s.q = (s_ff.s2 & s_ff.s3) | (s_ff.q & (s_ff.s2 | s_ff.s3));
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign level_o = s_ff.q;

endmodule : level_sync3

`default_nettype wire

// File: hw/interval_timer.sv
`timescale 1ns/1ps
`default_nettype none

module interval_timer
    import charger_cfg_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic [TMR_W-1:0] limit_i,
    output logic expire_o
);
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic expire;
    } tmr_state_t;

    tmr_state_t s_ff;
    tmr_state_t nxt_s;

    // Restart wins over counting; a limit of zero behaves as one cycle.
    always_comb begin
        nxt_s = s_ff;
        nxt_s.expire = 1'b0;
        if (restart_i) begin
            nxt_s.cnt = '0;
        end else if (run_i) begin
            if ((s_ff.cnt + TMR_W'(1)) >= limit_i) begin
                nxt_s.cnt = '0;
                nxt_s.expire = 1'b1;
            end else begin
                nxt_s.cnt = s_ff.cnt + TMR_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign expire_o = s_ff.expire;

endmodule : interval_timer

`default_nettype wire

// File: hw/charger_config_register_bank.sv
// Functional notes
// - Recharge disable bit 7; reset keeps recharge on.
// - Recharge threshold code 80..260 mV, reset 11.
// - Trickle-to-fast threshold code, reset 01.
// - Weak threshold 2.7..3.4 V, reset 011.
// - Complete timer enable; 31 ms deglitch stays.
// - Safety timer enable bit 4, reset 1.
// - Period bit picks 30s/300min or 60s/600min.
// - Watchdog off when its enable is clear.
// - Watchdog period 32 s or 64 s.
// - Writing one to kick restarts watchdog.
// - Device disable bit 6 shuts device down.
// - Monitor on if input valid or forced.
// - Thermistor source on if valid or forced.
// - Regulator off; isolation switch forced on while charging enable is clear, forced off while it is set.
// - End-of-charge permission bit 2, reset 1.
// - Charging enable bit 0, reset 0.
// - Watchdog alarm sets read-only alarm flag.
`timescale 1ns/1ps
`default_nettype none

module charger_config_register_bank
    import charger_cfg_pkg::*;
#(
    parameter logic [35:0] WD_SHORT_CYCLES = WD_SHORT_CYC,
    parameter logic [35:0] WD_LONG_CYCLES = WD_LONG_CYC,
    parameter logic [35:0] DEGLITCH_CYCLES = DEGLITCH_CYC
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire reg_req_t req_i,
    output logic [7:0] rdata_o,
    input wire logic input_valid_i,
    input wire logic battery_above_dead_i,
    input wire logic eoc_condition_i,
    input wire logic watchdog_alarm_clear_i,
    output var cfg_t cfg_o,
    output var analog_t analog_o,
    output logic watchdog_alarm_flag_o,
    output logic eoc_deglitched_o,
    output logic charge_termination_ok_o
);

    typedef struct packed {
        cfg_t cfg;
        logic [7:0] rdata;
        logic kick;
        logic alarm;
        logic eoc_det;
        logic term_ok;
        analog_t analog;
    } bank_state_t;

    localparam bank_state_t ST_RST = '{
        cfg: CFG_RST,
        rdata: 8'h00,
        kick: 1'b0,
        alarm: 1'b0,
        eoc_det: 1'b0,
        term_ok: 1'b0,
        analog: '0
    };

    bank_state_t s_ff;
    bank_state_t nxt_s;

    logic input_valid;
    logic battery_above_dead;
    logic eoc_condition;
    logic wd_run;
    logic wd_restart;
    logic wd_expire;
    logic [TMR_W-1:0] wd_limit;
    logic dg_expire;

    // Pin levels from the analog comparators are asynchronous to this clock.
    level_sync3 #(
        .W(3)
    ) u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .async_i({input_valid_i, battery_above_dead_i, eoc_condition_i}),
        .level_o({input_valid, battery_above_dead, eoc_condition})
    );

    // Readback assembly; unused positions and the kick bit are left at zero.
    function automatic logic [7:0] read_byte(input cfg_t c, input logic [7:0] addr);
        logic [7:0] b;
        b = 8'h00;
        if (addr == THRESH_OFS) begin
            b[RCH_DIS_BIT] = c.recharge_disable;
            b[RCH_SEL_LSB+:2] = c.recharge_threshold_sel;
            b[TRK_SEL_LSB+:2] = c.trickle_to_fast_threshold_sel;
            b[WEAK_SEL_LSB+:3] = c.weak_battery_threshold_sel;
        end else if (addr == TIMER_OFS) begin
            b[TEND_EN_BIT] = c.charge_complete_timer_enable;
            b[CHG_TMR_EN_BIT] = c.charge_safety_timer_enable;
            b[CHG_TMR_PER_BIT] = c.charge_timer_period_sel;
            b[WD_EN_BIT] = c.watchdog_enable;
            b[WD_PER_BIT] = c.watchdog_period_sel;
        end else if (addr == FUNC1_OFS) begin
            b[DEV_DIS_BIT] = c.device_disable;
            b[BMON_FORCE_BIT] = c.battery_monitor_force_on;
            b[THR_FORCE_BIT] = c.thermistor_source_force_on;
            b[REG_DIS_BIT] = c.regulator_disable;
            b[EOC_EN_BIT] = c.end_of_charge_enable;
            b[CHG_EN_BIT] = c.charging_enable;
        end
        return b;
    endfunction : read_byte

    // The watchdog only runs while enabled and the battery is past the dead level.
    assign wd_run = s_ff.cfg.watchdog_enable & battery_above_dead;
    assign wd_restart = s_ff.kick | ~wd_run;
    assign wd_limit = s_ff.cfg.watchdog_period_sel ? WD_LONG_CYCLES : WD_SHORT_CYCLES;

    interval_timer u_watchdog (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .run_i(wd_run),
        .restart_i(wd_restart),
        .limit_i(wd_limit),
        .expire_o(wd_expire)
    );

    // The end-of-charge deglitch stays in service whether or not the completion timer is on.
    interval_timer u_eoc_deglitch (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .run_i(eoc_condition),
        .restart_i(~eoc_condition),
        .limit_i(DEGLITCH_CYCLES),
        .expire_o(dg_expire)
    );

    // Register writes, read answers and the derived controls.
    always_comb begin
        nxt_s = s_ff;
        nxt_s.kick = 1'b0;
        if (req_i.wr) begin
            if (req_i.addr == THRESH_OFS) begin
                nxt_s.cfg.recharge_disable = req_i.wdata[RCH_DIS_BIT];
                nxt_s.cfg.recharge_threshold_sel = req_i.wdata[RCH_SEL_LSB+:2];
                nxt_s.cfg.trickle_to_fast_threshold_sel = req_i.wdata[TRK_SEL_LSB+:2];
                nxt_s.cfg.weak_battery_threshold_sel = req_i.wdata[WEAK_SEL_LSB+:3];
            end else if (req_i.addr == TIMER_OFS) begin
                nxt_s.cfg.charge_complete_timer_enable = req_i.wdata[TEND_EN_BIT];
                nxt_s.cfg.charge_safety_timer_enable = req_i.wdata[CHG_TMR_EN_BIT];
                nxt_s.cfg.charge_timer_period_sel = req_i.wdata[CHG_TMR_PER_BIT];
                nxt_s.cfg.watchdog_enable = req_i.wdata[WD_EN_BIT];
                nxt_s.cfg.watchdog_period_sel = req_i.wdata[WD_PER_BIT];
                nxt_s.kick = req_i.wdata[WD_KICK_BIT];
            end else if (req_i.addr == FUNC1_OFS) begin
                nxt_s.cfg.device_disable = req_i.wdata[DEV_DIS_BIT];
                nxt_s.cfg.battery_monitor_force_on = req_i.wdata[BMON_FORCE_BIT];
                nxt_s.cfg.thermistor_source_force_on = req_i.wdata[THR_FORCE_BIT];
                nxt_s.cfg.regulator_disable = req_i.wdata[REG_DIS_BIT];
                nxt_s.cfg.end_of_charge_enable = req_i.wdata[EOC_EN_BIT];
                nxt_s.cfg.charging_enable = req_i.wdata[CHG_EN_BIT];
            end
        end
        // A read returns the value held before any write in the same cycle.
        if (req_i.rd) begin
            nxt_s.rdata = read_byte(s_ff.cfg, req_i.addr);
        end
        // The alarm is sticky; an expiry in the clearing cycle is kept.
        if (wd_expire) begin
            nxt_s.alarm = 1'b1;
        end else if (watchdog_alarm_clear_i) begin
            nxt_s.alarm = 1'b0;
        end
        // The deglitched level drops at once when the condition goes away.
        if (!eoc_condition) begin
            nxt_s.eoc_det = 1'b0;
        end else if (dg_expire) begin
            nxt_s.eoc_det = 1'b1;
        end
        nxt_s.term_ok = s_ff.eoc_det & s_ff.cfg.end_of_charge_enable;
        nxt_s.analog.battery_monitor_on = input_valid
            | s_ff.cfg.battery_monitor_force_on;
        nxt_s.analog.thermistor_source_on = input_valid
            | s_ff.cfg.thermistor_source_force_on;
        nxt_s.analog.regulator_on = ~s_ff.cfg.regulator_disable;
        nxt_s.analog.iso_switch_forced_on = s_ff.cfg.regulator_disable & ~s_ff.cfg.charging_enable;
        nxt_s.analog.iso_switch_forced_off = s_ff.cfg.regulator_disable & s_ff.cfg.charging_enable;
        nxt_s.analog.device_shutdown = s_ff.cfg.device_disable;
    end

    // Single state register for the whole bank.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_ff <= ST_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Every output is a field of the state register.
    assign rdata_o = s_ff.rdata;
    assign cfg_o = s_ff.cfg;
    assign analog_o = s_ff.analog;
    assign watchdog_alarm_flag_o = s_ff.alarm;
    assign eoc_deglitched_o = s_ff.eoc_det;
    assign charge_termination_ok_o = s_ff.term_ok;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence seq_write_thresh;
        req_i.wr && !req_i.rd && req_i.addr == THRESH_OFS;
    endsequence

    sequence seq_read_thresh;
        !req_i.wr && req_i.rd && req_i.addr == THRESH_OFS;
    endsequence

    sequence seq_kick_write;
        req_i.wr && req_i.addr == TIMER_OFS && req_i.wdata[WD_KICK_BIT];
    endsequence

    AST_THRESH_READBACK: assert property (seq_write_thresh ##1 seq_read_thresh |=>
        rdata_o == $past(req_i.wdata, 2))
        else $error("threshold register readback differs from written value");

    AST_TIMER_ZERO_BITS: assert property (
        $past(req_i.rd) && $past(req_i.addr) == TIMER_OFS |->
        rdata_o[7:6] == 2'b00 && rdata_o[WD_KICK_BIT] == 1'b0)
        else $error("timer register unused or kick bit read as one");

    AST_FUNC1_ZERO_BITS: assert property (
        $past(req_i.rd) && $past(req_i.addr) == FUNC1_OFS |->
        rdata_o[7] == 1'b0 && rdata_o[1] == 1'b0)
        else $error("function register unused bit read as one");

    AST_KICK_RESTARTS: assert property (seq_kick_write |=> wd_restart ##1 !wd_expire)
        else $error("watchdog kick did not restart the watchdog");

    AST_WD_DISABLED: assert property (!s_ff.cfg.watchdog_enable [*2] |-> !wd_expire)
        else $error("watchdog expired while disabled");

    AST_ALARM_SET: assert property (wd_expire |=> watchdog_alarm_flag_o)
        else $error("watchdog expiry did not set the alarm flag");

    AST_ALARM_CAUSE: assert property (
        $rose(watchdog_alarm_flag_o) |-> $past(wd_expire))
        else $error("alarm flag rose without watchdog expiry");

    AST_MONITOR_ON: assert property (analog_o.battery_monitor_on ==
        $past(input_valid | cfg_o.battery_monitor_force_on))
        else $error("battery monitor control does not follow supply or force bit");

    AST_THERM_ON: assert property (analog_o.thermistor_source_on ==
        $past(input_valid | cfg_o.thermistor_source_force_on))
        else $error("thermistor source control does not follow supply or force bit");

    AST_ISO_SWITCH: assert property (
        (cfg_o.regulator_disable && !cfg_o.charging_enable) [*2] |->
        analog_o.iso_switch_forced_on && !analog_o.regulator_on)
        else $error("isolation switch not forced on with regulator off and charging off");

    AST_TERM_GATED: assert property (charge_termination_ok_o |->
        $past(cfg_o.end_of_charge_enable) && $past(eoc_deglitched_o))
        else $error("termination allowed without permission bit or deglitch");

    AST_CHG_EN_WRITE: assert property (req_i.wr && req_i.addr == FUNC1_OFS |=>
        cfg_o.charging_enable == $past(req_i.wdata[CHG_EN_BIT]))
        else $error("charging enable did not take the written value");

    // Each written field shows on cfg_o one edge after the strobe.
    AST_RCH_DIS_WRITE: assert property (req_i.wr && req_i.addr == THRESH_OFS |=>
        cfg_o.recharge_disable == $past(req_i.wdata[RCH_DIS_BIT]))
        else $error("recharge disable did not take the written value");

    AST_WEAK_SEL_WRITE: assert property (req_i.wr && req_i.addr == THRESH_OFS |=>
        cfg_o.weak_battery_threshold_sel == $past(req_i.wdata[WEAK_SEL_LSB+:3]))
        else $error("weak battery threshold did not take the written value");

    AST_SAFETY_EN_WRITE: assert property (req_i.wr && req_i.addr == TIMER_OFS |=>
        cfg_o.charge_safety_timer_enable == $past(req_i.wdata[CHG_TMR_EN_BIT]))
        else $error("safety timer enable did not take the written value");

    AST_PERIOD_WRITE: assert property (req_i.wr && req_i.addr == TIMER_OFS |=>
        cfg_o.charge_timer_period_sel == $past(req_i.wdata[CHG_TMR_PER_BIT]))
        else $error("charge timer period did not take the written value");

    // Derived controls lag the fields by one edge; the regulator bit is used as an
    // antecedent so that the reset value of the controls never trips a check.
    AST_SHUTDOWN: assert property (
        analog_o.device_shutdown == $past(cfg_o.device_disable))
        else $error("shutdown control does not follow the device disable bit");

    AST_ISO_OFF: assert property (
        $past(cfg_o.regulator_disable && cfg_o.charging_enable) |->
        analog_o.iso_switch_forced_off && !analog_o.iso_switch_forced_on
        && !analog_o.regulator_on)
        else $error("isolation switch not forced off with regulator off and charging on");

    // The deglitched level rises only on a full wait and falls with the condition.
    AST_EOC_DROP: assert property (!eoc_condition |=> !eoc_deglitched_o)
        else $error("deglitched end-of-charge level held after the condition fell");

    AST_EOC_CAUSE: assert property ($rose(eoc_deglitched_o) |-> $past(dg_expire))
        else $error("deglitched end-of-charge level rose without a full deglitch wait");

    // Addresses outside the bank read back as zero.
    AST_UNMAPPED_ZERO: assert property (
        $past(req_i.rd) && ($past(req_i.addr) < THRESH_OFS || $past(req_i.addr) > FUNC1_OFS)
        |-> rdata_o == 8'h00)
        else $error("read of an address outside the bank returned nonzero data");

endmodule : charger_config_register_bank

`default_nettype wire

// File: test/host_req_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_req_model
    import charger_cfg_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic [7:0] rdata_i,
    output var reg_req_t req_o
);

    // Bus idles with no strobe raised until the first access.
    initial begin
        req_o = '0;
    end

    // One byte access: strobe raised for exactly one rising edge.
    // A write of one to the kick bit is how this host restarts the watchdog.
    task automatic bus_cycle(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                             output logic [7:0] rdata);
        @(negedge ref_clk_i);
        req_o.wr = wr;
        req_o.rd = !wr;
        req_o.addr = addr;
        req_o.wdata = wdata;
        @(negedge ref_clk_i);
        rdata = rdata_i;
        // Released lines show the inverse so a stale value never looks valid.
        req_o.wr = 1'b0;
        req_o.rd = 1'b0;
        req_o.addr = ~addr;
        req_o.wdata = ~wdata;
    endtask : bus_cycle

    // A write and a read of one register on back-to-back edges; the read sees the new value.
    task automatic write_then_read(input logic [7:0] addr, input logic [7:0] wdata,
                                   output logic [7:0] rdata);
        @(negedge ref_clk_i);
        req_o.wr = 1'b1;
        req_o.rd = 1'b0;
        req_o.addr = addr;
        req_o.wdata = wdata;
        @(negedge ref_clk_i);
        req_o.wr = 1'b0;
        req_o.rd = 1'b1;
        @(negedge ref_clk_i);
        rdata = rdata_i;
        req_o.rd = 1'b0;
        req_o.addr = ~addr;
        req_o.wdata = ~wdata;
    endtask : write_then_read

endmodule : host_req_model

`default_nettype wire

// File: test/charger_config_register_bank_test.sv
`timescale 1ns/1ps
`default_nettype none

module charger_config_register_bank_test
    import charger_cfg_pkg::*;
;
    // Shortened counts so the timers expire within a short run.
    localparam int WD_S = 40;
    localparam int WD_L = 80;
    localparam int DG = 10;

    logic clk;
    logic arst_n;
    reg_req_t req;
    logic [7:0] rdata;
    logic input_valid;
    logic batt_above_dead;
    logic eoc_cond;
    logic alarm_clr;
    cfg_t cfg;
    analog_t analog;
    logic alarm;
    logic eoc_dg;
    logic term_ok;
    int errors;
    int check_count;

    charger_config_register_bank #(
        .WD_SHORT_CYCLES(36'(WD_S)),
        .WD_LONG_CYCLES(36'(WD_L)),
        .DEGLITCH_CYCLES(36'(DG))
    ) dut_u (
        .ref_clk_i(clk),
        .arst_n_i(arst_n),
        .req_i(req),
        .rdata_o(rdata),
        .input_valid_i(input_valid),
        .battery_above_dead_i(batt_above_dead),
        .eoc_condition_i(eoc_cond),
        .watchdog_alarm_clear_i(alarm_clr),
        .cfg_o(cfg),
        .analog_o(analog),
        .watchdog_alarm_flag_o(alarm),
        .eoc_deglitched_o(eoc_dg),
        .charge_termination_ok_o(term_ok)
    );

    host_req_model host_u (
        .ref_clk_i(clk),
        .rdata_i(rdata),
        .req_o(req)
    );

    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] unused;
        host_u.bus_cycle(1'b1, a, d, unused);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        host_u.bus_cycle(1'b0, a, 8'h00, d);
    endtask : rd

    // Counts cycles until the alarm flag, or the deglitched level if sel_dg, rises; bounded.
    task automatic wait_high(input logic sel_dg, output int n);
        n = 0;
        while ((sel_dg ? eoc_dg : alarm) !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_high

    task automatic reset_values_test();
        logic [7:0] v;
        rd(THRESH_OFS, v);
        check(v, 8'h6B);
        rd(TIMER_OFS, v);
        check(v, 8'h38);
        rd(FUNC1_OFS, v);
        check(v, 8'h04);
        check(8'(cfg.charging_enable), 8'h00);
    endtask : reset_values_test

    // Every code of each threshold field, each decoded field checked.
    task automatic threshold_codes_test();
        logic [7:0] v;
        logic [7:0] d;
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            d = {c[0], c[1:0], c[2:1], c};
            host_u.write_then_read(THRESH_OFS, d, v);
            check(v, d);
            check(8'(cfg.recharge_disable), 8'(c[0]));
            check(8'(cfg.recharge_threshold_sel), 8'(c[1:0]));
            check(8'(cfg.trickle_to_fast_threshold_sel), 8'(c[2:1]));
            check(8'(cfg.weak_battery_threshold_sel), 8'(c));
        end
    endtask : threshold_codes_test

    task automatic timer_fields_test();
        logic [7:0] v;
        wr(TIMER_OFS, 8'hFF);
        rd(TIMER_OFS, v);
        check(v, 8'h3E);
        wr(TIMER_OFS, 8'h14);
        check(8'({cfg.charge_complete_timer_enable, cfg.charge_safety_timer_enable,
                  cfg.charge_timer_period_sel, cfg.watchdog_enable,
                  cfg.watchdog_period_sel}), 8'h0A);
        wr(TIMER_OFS, 8'h00);
    endtask : timer_fields_test

    // Analog controls follow the register one cycle behind the fields.
    task automatic func_analog_test();
        logic [7:0] v;
        wr(FUNC1_OFS, 8'hFF);
        rd(FUNC1_OFS, v);
        check(v, 8'h7D);
        @(negedge clk);
        check(8'(analog), 8'h33);
        wr(FUNC1_OFS, 8'h08);
        repeat (2) @(negedge clk);
        check(8'(analog), 8'h04);
        input_valid = 1'b1;
        repeat (6) @(negedge clk);
        wr(FUNC1_OFS, 8'h05);
        repeat (2) @(negedge clk);
        check(8'(analog), 8'h38);
        check(8'(cfg.charging_enable), 8'h01);
        wr(FUNC1_OFS, 8'h04);
    endtask : func_analog_test

    task automatic unmapped_test();
        logic [7:0] v;
        wr(8'h08, 8'h00);
        rd(8'h08, v);
        check(v, 8'h00);
        rd(8'h04, v);
        check(v, 8'h00);
        rd(THRESH_OFS, v);
        check(v, 8'hFF);
    endtask : unmapped_test

    task automatic clear_alarm();
        @(negedge clk);
        alarm_clr = 1'b1;
        @(negedge clk);
        alarm_clr = 1'b0;
        @(negedge clk);
    endtask : clear_alarm

    task automatic watchdog_test();
        int n;
        batt_above_dead = 1'b1;
        // Kicks well inside the period keep the alarm away.
        repeat (5) begin
            wr(TIMER_OFS, 8'h05);
            repeat (25) @(negedge clk);
        end
        check(8'(alarm), 8'h00);
        wr(TIMER_OFS, 8'h05);
        wait_high(1'b0, n);
        check(8'(n >= WD_S - 4 && n <= WD_S + 6), 8'h01);
        clear_alarm();
        check(8'(alarm), 8'h00);
        wr(TIMER_OFS, 8'h07);
        wait_high(1'b0, n);
        check(8'(n >= WD_L - 4 && n <= WD_L + 6), 8'h01);
        clear_alarm();
        wr(TIMER_OFS, 8'h01);
        repeat (2 * WD_L) @(negedge clk);
        check(8'(alarm), 8'h00);
    endtask : watchdog_test

    // Complete timer disabled: the deglitch filter must still run.
    task automatic eoc_test();
        int n;
        wr(TIMER_OFS, 8'h00);
        eoc_cond = 1'b1;
        repeat (6) @(negedge clk);
        eoc_cond = 1'b0;
        repeat (8) @(negedge clk);
        check(8'(eoc_dg), 8'h00);
        eoc_cond = 1'b1;
        wait_high(1'b1, n);
        check(8'(n >= DG + 1 && n <= DG + 7), 8'h01);
        @(negedge clk);
        check(8'(term_ok), 8'h01);
        wr(FUNC1_OFS, 8'h00);
        @(negedge clk);
        check(8'(term_ok), 8'h00);
        eoc_cond = 1'b0;
    endtask : eoc_test

    task automatic conclude();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // Main sequence: reset, then each scenario in turn.
    initial begin
        errors = 0;
        check_count = 0;
        arst_n = 1'b0;
        input_valid = 1'b0;
        batt_above_dead = 1'b0;
        eoc_cond = 1'b0;
        alarm_clr = 1'b0;
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
        reset_values_test();
        threshold_codes_test();
        timer_fields_test();
        func_analog_test();
        unmapped_test();
        watchdog_test();
        eoc_test();
        conclude();
    end

    // The scenarios need a few hundred cycles; this limit is far beyond that.
    initial begin
        #100us;
        errors++;
        $display("watchdog timeout reached");
        conclude();
    end

endmodule : charger_config_register_bank_test

`default_nettype wire
